// file: hw/apt_pkg.sv
`default_nettype none
package apt_pkg;

  // ----------------------------------------------------------------
  // Command set
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APT_OP_POL  = 2'h0,
    APT_OP_COM  = 2'h1,
    APT_OP_STEP = 2'h2
  } apt_op_e;

  typedef enum logic [1:0] {
    APT_NV_POL  = 2'h0,
    APT_NV_COM  = 2'h1,
    APT_NV_STEP = 2'h2
  } apt_nv_e;

  localparam logic       STORE_RAM     = 1'b0;
  localparam logic       STORE_NV      = 1'b1;

  // ----------------------------------------------------------------
  // Operand ranges
  // ----------------------------------------------------------------
  localparam logic [2:0] AXIS_MIN      = 3'h1;
  localparam logic [2:0] POL_AXIS_MAX  = 3'h4;
  localparam logic [2:0] COM_AXIS_MAX  = 3'h6;
  localparam logic [2:0] STEP_AXIS_MAX = 3'h4;
  localparam logic [4:0] ITEM_MIN      = 5'h01;
  localparam logic [4:0] COM_ITEM_MAX  = 5'h03;
  localparam logic [4:0] STEP_ITEM_MAX = 5'h11;
  localparam logic [8:0] STEP_MAX      = 9'h190;
  localparam int         NUM_AXES      = 4;
  localparam int         NUM_BUSY      = 6;

  // ----------------------------------------------------------------
  // Polarity word: bit set = normally closed contact
  // ----------------------------------------------------------------
  localparam int         POL_BITS      = 16;
  localparam int         POL_USED      = 8;
  localparam int         POL_UPPER     = 0;
  localparam int         POL_LOWER     = 1;
  localparam int         POL_DOG       = 2;
  localparam int         POL_HOME      = 3;
  localparam int         POL_ESTOP     = 4;
  localparam int         POL_DRV_RDY   = 5;
  localparam int         POL_SERVO_ON  = 6;
  localparam int         POL_SERVO_RST = 7;
  localparam logic [15:0] POL_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Common parameter items
  // ----------------------------------------------------------------
  localparam logic [4:0]  COM_PULSE_LVL = 5'h01;
  localparam logic [4:0]  COM_OVR_MODE  = 5'h02;
  localparam logic [4:0]  COM_PERIOD    = 5'h03;
  localparam logic [31:0] PERIOD_MIN    = 32'h0000_0001;
  localparam logic [31:0] PERIOD_MAX    = 32'h0000_000A;
  localparam logic [3:0]  PERIOD_RESET  = 4'h1;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_VALUE     = 5'h00;
  localparam logic [4:0]  REG_SEL       = 5'h04;
  localparam logic [4:0]  REG_GO        = 5'h08;
  localparam logic [4:0]  REG_STATUS    = 5'h0C;
  localparam logic [4:0]  REG_NVCNT     = 5'h10;
  localparam int          SEL_OP_LSB    = 0;
  localparam int          SEL_AXIS_LSB  = 4;
  localparam int          SEL_ITEM_LSB  = 8;
  localparam int          SEL_STEP_LSB  = 16;
  localparam int          SEL_NV_BIT    = 31;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_DONE       = 1;
  localparam int          ST_ERR        = 2;
  localparam int          ST_LIMIT      = 3;
  localparam logic [19:0] NV_WR_LIMIT   = 20'hF4240;

endpackage : apt_pkg
`default_nettype wire

// file: hw/apt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface apt_if;
  import apt_pkg::*;
  logic          cmd_valid;
  apt_op_e       cmd_op;
  logic [2:0]    cmd_axis;
  logic [31:0]   cmd_value;
  logic [4:0]    cmd_item;
  logic [8:0]    cmd_step;
  logic          cmd_nv;
  logic          rsp_valid;
  logic          rsp_err;

  modport dev  (input  cmd_valid, cmd_op, cmd_axis, cmd_value, cmd_item, cmd_step, cmd_nv,
                output rsp_valid, rsp_err);
  modport host (output cmd_valid, cmd_op, cmd_axis, cmd_value, cmd_item, cmd_step, cmd_nv,
                input  rsp_valid, rsp_err);
endinterface : apt_if
`default_nettype wire

// file: hw/apt_dev.sv
// Functional notes
// - Storage selector 0 volatile, 1 also flash.
// - Volatile values lost at power-off; flash kept.
// - Controller caps flash writes at 1,000,000.
// - Polarity command refused while axis operates.
// - Polarity bit set means normally closed contact.
// - Polarity bits 0-7 signals, 8-15 unused.
// - Polarity command: axes 1-4, 32-bit value.
// - Common command: axes 1-6, items 1-3.
// - Common flash writes have no count limit.
// - Common item 1: pulse output level.
// - Common item 2: override percent or speed.
// - Item 3 period 1-10 ms, else kept.
// - Common command refused while axis operates.
// - Step command: axes 1-4, items 1-17, steps 0-400.
// - Running step change applied after step ends.
// - Step flash commit covers only addressed axis.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module apt_dev
  import apt_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        srst,
  apt_if.dev                               link,
  input  wire logic [NUM_BUSY-1:0]         axis_busy,
  input  wire logic [NUM_AXES-1:0][8:0]    exec_step,
  input  wire logic [NUM_AXES-1:0]         step_done,
  output logic      [NUM_AXES-1:0][15:0]   pol_word_r,
  output logic                             pulse_high_r,
  output logic                             override_abs_r,
  output logic      [3:0]                  ctrl_period_r,
  output logic                             step_wr_r,
  output logic      [1:0]                  step_wr_axis_r,
  output logic      [8:0]                  step_wr_step_r,
  output logic      [4:0]                  step_wr_item_r,
  output logic      [31:0]                 step_wr_val_r,
  output logic                             nv_req_r,
  output apt_nv_e                          nv_kind_r,
  output logic      [2:0]                  nv_axis_r
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input apt_op_e op, input logic [2:0] ax,
                                    input logic [4:0] it, input logic [8:0] st);
    unique case (op)
      APT_OP_POL:  return (ax >= AXIS_MIN) && (ax <= POL_AXIS_MAX);
      APT_OP_COM:  return (ax >= AXIS_MIN) && (ax <= COM_AXIS_MAX)
                          && (it >= ITEM_MIN) && (it <= COM_ITEM_MAX);
      APT_OP_STEP: return (ax >= AXIS_MIN) && (ax <= STEP_AXIS_MAX)
                          && (it >= ITEM_MIN) && (it <= STEP_ITEM_MAX) && (st <= STEP_MAX);
      default:     return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Command qualification
  // ----------------------------------------------------------------
  logic                        legal;
  logic [2:0]                  ai;
  logic                        busy;
  logic                        defer;
  logic                        refuse;
  logic                        accept;
  logic                        direct_wr;
  logic [NUM_AXES-1:0]         pend_v_r;
  logic [NUM_AXES-1:0][8:0]    pend_step_r;
  logic [NUM_AXES-1:0][4:0]    pend_item_r;
  logic [NUM_AXES-1:0][31:0]   pend_val_r;
  logic [NUM_AXES-1:0]         done_seen_r;
  logic [NUM_AXES-1:0]         released;
  logic                        rel_any;
  logic [1:0]                  rel_i;

  always_comb
  begin
    legal  = in_range(link.cmd_op, link.cmd_axis, link.cmd_item, link.cmd_step);
    ai     = 3'(link.cmd_axis - AXIS_MIN);
    busy   = legal && axis_busy[ai];
    defer  = 1'b0;
    refuse = !legal;
    if (legal)
    begin
      unique case (link.cmd_op)
        APT_OP_POL:  refuse = busy;
        APT_OP_COM:  refuse = busy;
        APT_OP_STEP:
        begin
          defer  = busy && (link.cmd_step == exec_step[ai[1:0]]);
          refuse = defer && pend_v_r[ai[1:0]];
        end
        default:     refuse = 1'b1;
      endcase
    end
    accept    = link.cmd_valid && !refuse;
    direct_wr = accept && (link.cmd_op == APT_OP_STEP) && !defer;
  end

  // Lowest-index pending change whose step has ended, when the port is free
  always_comb
  begin
    rel_any  = 1'b0;
    rel_i    = 2'h0;
    released = '0;
    for (int a = NUM_AXES - 1; a >= 0; a--)
    begin
      if (pend_v_r[a] && done_seen_r[a])
      begin
        rel_any = 1'b1;
        rel_i   = 2'(a);
      end
    end
    if (rel_any && !direct_wr)
      released[rel_i] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Answer to the controller
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      link.rsp_valid <= 1'b0;
      link.rsp_err   <= 1'b0;
    end
    else
    begin
      link.rsp_valid <= link.cmd_valid;
      link.rsp_err   <= link.cmd_valid && refuse;
    end
  end

  // ----------------------------------------------------------------
  // Signal polarity words
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      pol_word_r <= {NUM_AXES{POL_RESET}};
    else if (accept && (link.cmd_op == APT_OP_POL))
    begin
      // Low byte maps one signal per bit, upper byte kept clear
      pol_word_r[ai[1:0]] <= {{(POL_BITS-POL_USED){1'b0}},
                              link.cmd_value[POL_USED-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // Common parameters
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pulse_high_r   <= 1'b0;
      override_abs_r <= 1'b0;
      ctrl_period_r  <= PERIOD_RESET;
    end
    else if (accept && (link.cmd_op == APT_OP_COM))
    begin
      if (link.cmd_item == COM_PULSE_LVL)
        pulse_high_r <= link.cmd_value[0];
      if (link.cmd_item == COM_OVR_MODE)
        override_abs_r <= link.cmd_value[0];
      if ((link.cmd_item == COM_PERIOD) && ($signed(link.cmd_value) >= $signed(PERIOD_MIN))
          && ($signed(link.cmd_value) <= $signed(PERIOD_MAX)))
        ctrl_period_r <= link.cmd_value[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Deferred step changes
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pend_v_r    <= '0;
      pend_step_r <= '0;
      pend_item_r <= '0;
      pend_val_r  <= '0;
    end
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        if (accept && defer && (ai[1:0] == 2'(a)))
        begin
          pend_v_r[a]    <= 1'b1;
          pend_step_r[a] <= link.cmd_step;
          pend_item_r[a] <= link.cmd_item;
          pend_val_r[a]  <= link.cmd_value;
        end
        else if (released[a])
          pend_v_r[a] <= 1'b0;
      end
    end
  end

  // Step end is remembered until the held change has gone out
  always_ff @(posedge clock)
  begin
    if (srst)
      done_seen_r <= '0;
    else
      done_seen_r <= step_done | (done_seen_r & pend_v_r & ~released);
  end

  // ----------------------------------------------------------------
  // Step data write port
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      step_wr_r      <= 1'b0;
      step_wr_axis_r <= 2'h0;
      step_wr_step_r <= 9'h000;
      step_wr_item_r <= 5'h00;
      step_wr_val_r  <= 32'h0000_0000;
    end
    else if (direct_wr)
    begin
      step_wr_r      <= 1'b1;
      step_wr_axis_r <= ai[1:0];
      step_wr_step_r <= link.cmd_step;
      step_wr_item_r <= link.cmd_item;
      step_wr_val_r  <= link.cmd_value;
    end
    else if (rel_any)
    begin
      step_wr_r      <= 1'b1;
      step_wr_axis_r <= rel_i;
      step_wr_step_r <= pend_step_r[rel_i];
      step_wr_item_r <= pend_item_r[rel_i];
      step_wr_val_r  <= pend_val_r[rel_i];
    end
    else
      step_wr_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Flash commit requests; working copies above are volatile
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      nv_req_r  <= 1'b0;
      nv_kind_r <= APT_NV_POL;
      nv_axis_r <= 3'h0;
    end
    else
    begin
      nv_req_r <= accept && (link.cmd_nv == STORE_NV);
      if (accept)
      begin
        nv_axis_r <= link.cmd_axis;
        nv_kind_r <= apt_nv_e'(link.cmd_op);
      end
    end
  end

endmodule // apt_dev
`default_nettype wire

// file: hw/apt_host.sv
`timescale 1ns/10ps
`default_nettype none
module apt_host
  import apt_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          srst,
  apt_if.host                link,
  input  wire logic [4:0]    sw_addr,
  input  wire logic [31:0]   sw_wdata,
  input  wire logic          sw_wr,
  input  wire logic          sw_rd,
  output logic      [31:0]   sw_rdata_r
);

  typedef enum logic [1:0] {
    APT_H_IDLE = 2'b01,
    APT_H_WAIT = 2'b10
  } apt_hst_e;

  apt_hst_e     state_r;
  logic [31:0]  value_r;
  logic [31:0]  sel_r;
  logic         done_r;
  logic         err_r;
  logic         limit_r;
  logic [19:0]  nv_cnt_r;
  logic         cmd_valid_r;
  logic         go;
  logic         counted;
  logic         at_limit;

  assign go       = sw_wr && (sw_addr == REG_GO) && (state_r == APT_H_IDLE);
  assign counted  = sel_r[SEL_NV_BIT]
                    && (apt_op_e'(sel_r[SEL_OP_LSB+:2]) != APT_OP_COM);
  assign at_limit = counted && (nv_cnt_r == NV_WR_LIMIT);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      value_r <= 32'h0000_0000;
      sel_r   <= 32'h0000_0000;
    end
    else if (sw_wr && (state_r == APT_H_IDLE))
    begin
      if (sw_addr == REG_VALUE)
      begin
        value_r <= sw_wdata;
      end
      if (sw_addr == REG_SEL)
      begin
        sel_r <= sw_wdata;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sw_rdata_r <= 32'h0000_0000;
    end
    else if (sw_rd)
    begin
      unique case (sw_addr)
        REG_VALUE:  sw_rdata_r <= value_r;
        REG_SEL:    sw_rdata_r <= sel_r;
        REG_STATUS: sw_rdata_r <= {28'h0000000, limit_r, err_r, done_r,
                                   (state_r == APT_H_WAIT)};
        REG_NVCNT:  sw_rdata_r <= {12'h000, nv_cnt_r};
        default:    sw_rdata_r <= 32'h0000_0000;
      endcase
    end
    else
    begin
      sw_rdata_r <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r     <= APT_H_IDLE;
      cmd_valid_r <= 1'b0;
      done_r      <= 1'b0;
      err_r       <= 1'b0;
      limit_r     <= 1'b0;
    end
    else
    begin
      cmd_valid_r <= 1'b0;
      unique case (state_r)
        APT_H_IDLE:
        begin
          if (go)
          begin
            done_r  <= at_limit;
            err_r   <= at_limit;
            limit_r <= at_limit;
            if (!at_limit)
            begin
              cmd_valid_r <= 1'b1;
              state_r     <= APT_H_WAIT;
            end
          end
        end
        APT_H_WAIT:
        begin
          if (link.rsp_valid)
          begin
            done_r  <= 1'b1;
            err_r   <= link.rsp_err;
            state_r <= APT_H_IDLE;
          end
        end
      endcase
    end
  end

  // Successful flash writes of polarity and step data are counted
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      nv_cnt_r <= 20'h00000;
    end
    else if ((state_r == APT_H_WAIT) && link.rsp_valid && !link.rsp_err && counted)
    begin
      nv_cnt_r <= 20'(nv_cnt_r + 20'h00001);
    end
  end

  assign link.cmd_valid = cmd_valid_r;
  assign link.cmd_op    = apt_op_e'(sel_r[SEL_OP_LSB+:2]);
  assign link.cmd_axis  = sel_r[SEL_AXIS_LSB+:3];
  assign link.cmd_item  = sel_r[SEL_ITEM_LSB+:5];
  assign link.cmd_step  = sel_r[SEL_STEP_LSB+:9];
  assign link.cmd_nv    = sel_r[SEL_NV_BIT];
  assign link.cmd_value = value_r;

endmodule // apt_host
`default_nettype wire

// file: testbench/apt_properties.sv
`timescale 1ns/10ps
`default_nettype none
module apt_properties
  import apt_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire apt_op_e     cmd_op,
  input wire logic [2:0]  cmd_axis,
  input wire logic [31:0] cmd_value,
  input wire logic [4:0]  cmd_item,
  input wire logic [8:0]  cmd_step,
  input wire logic        cmd_nv,
  input wire logic        rsp_valid,
  input wire logic        rsp_err
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Command shapes
  // ----------------------------------------------------------------
  sequence s_bad_pol;
    cmd_valid && cmd_op == APT_OP_POL && (cmd_axis < AXIS_MIN || cmd_axis > POL_AXIS_MAX);
  endsequence

  sequence s_bad_com;
    cmd_valid && cmd_op == APT_OP_COM && (cmd_axis < AXIS_MIN || cmd_axis > COM_AXIS_MAX
      || cmd_item < ITEM_MIN || cmd_item > COM_ITEM_MAX);
  endsequence

  sequence s_bad_step;
    cmd_valid && cmd_op == APT_OP_STEP && (cmd_axis < AXIS_MIN || cmd_axis > STEP_AXIS_MAX
      || cmd_item < ITEM_MIN || cmd_item > STEP_ITEM_MAX || cmd_step > STEP_MAX);
  endsequence

  sequence s_refused;
    rsp_valid && rsp_err;
  endsequence

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pol_range_a: assert property (s_bad_pol |=> s_refused)
    else $error("polarity axis out of range accepted");
  com_range_a: assert property (s_bad_com |=> s_refused)
    else $error("common operand out of range accepted");
  step_range_a: assert property (s_bad_step |=> s_refused)
    else $error("step operand out of range accepted");
  rsp_follow_a: assert property (cmd_valid |=> rsp_valid)
    else $error("no response one cycle after command");
  rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("response without command");
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command issued before response");
  nv_hold_a: assert property (cmd_valid |=> $stable(cmd_nv))
    else $error("storage selector changed during command");
  fields_hold_a: assert property (cmd_valid |=> $stable(cmd_value) && $stable(cmd_axis)
    && $stable(cmd_item) && $stable(cmd_step))
    else $error("command fields changed during command");
endmodule // apt_properties
`default_nettype wire

// file: testbench/axis_param_teach_cmds_bench.sv
`timescale 1ns/10ps
`default_nettype none
module axis_param_teach_cmds_bench;
  import apt_pkg::*;
  logic                      clock;
  logic                      srst;
  logic [4:0]                sw_addr;
  logic [31:0]               sw_wdata;
  logic                      sw_wr;
  logic                      sw_rd;
  logic [31:0]               sw_rdata_r;
  logic [NUM_BUSY-1:0]       axis_busy;
  logic [NUM_AXES-1:0][8:0]  exec_step;
  logic [NUM_AXES-1:0]       step_done;
  logic [NUM_AXES-1:0][15:0] pol_word_r;
  logic                      pulse_high_r;
  logic                      override_abs_r;
  logic [3:0]                ctrl_period_r;
  logic                      step_wr_r;
  logic [1:0]                step_wr_axis_r;
  logic [8:0]                step_wr_step_r;
  logic [4:0]                step_wr_item_r;
  logic [31:0]               step_wr_val_r;
  logic                      nv_req_r;
  apt_nv_e                   nv_kind_r;
  logic [2:0]                nv_axis_r;
  int                        error_cnt = 0;
  int                        checked = 0;
  int                        nv_seen = 0;
  int                        wr_seen = 0;
  int                        nvcnt_m = 0;
  logic [15:0]               pol_m [NUM_AXES];
  logic                      pulse_m = 1'b0;
  logic                      ovr_m = 1'b0;
  logic [3:0]                per_m = PERIOD_RESET;
  logic [3:0]                held_m = 4'h0;
  logic [4:0]                nv_l;
  logic [47:0]               wr_l;

  apt_if apt_if_inst ();
  apt_host apt_host_inst (.clock(clock), .srst(srst), .link(apt_if_inst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r));
  apt_dev apt_dev_inst (.clock(clock), .srst(srst), .link(apt_if_inst),
    .axis_busy(axis_busy), .exec_step(exec_step), .step_done(step_done),
    .pol_word_r(pol_word_r), .pulse_high_r(pulse_high_r), .override_abs_r(override_abs_r),
    .ctrl_period_r(ctrl_period_r), .step_wr_r(step_wr_r), .step_wr_axis_r(step_wr_axis_r),
    .step_wr_step_r(step_wr_step_r), .step_wr_item_r(step_wr_item_r),
    .step_wr_val_r(step_wr_val_r), .nv_req_r(nv_req_r), .nv_kind_r(nv_kind_r),
    .nv_axis_r(nv_axis_r));
  apt_properties apt_properties_inst (.clock(clock), .srst(srst),
    .cmd_valid(apt_if_inst.cmd_valid), .cmd_op(apt_if_inst.cmd_op),
    .cmd_axis(apt_if_inst.cmd_axis), .cmd_value(apt_if_inst.cmd_value),
    .cmd_item(apt_if_inst.cmd_item), .cmd_step(apt_if_inst.cmd_step),
    .cmd_nv(apt_if_inst.cmd_nv), .rsp_valid(apt_if_inst.rsp_valid),
    .rsp_err(apt_if_inst.rsp_err));

  // ----------------------------------------------------------------
  // Clock and pulse capture
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(negedge clock)
  begin
    if (nv_req_r === 1'b1)
    begin
      nv_seen++;
      nv_l = {nv_kind_r, nv_axis_r};
    end
    if (step_wr_r === 1'b1)
    begin
      wr_seen++;
      wr_l = {step_wr_axis_r, step_wr_item_r, step_wr_step_r, step_wr_val_r};
    end
  end

  // ----------------------------------------------------------------
  // Compare, bus and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic sw_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 d = sw_rdata_r;
  endtask

  function automatic logic exp_bad(input logic [1:0] op, input logic [2:0] ax,
    input logic [4:0] it, input logic [8:0] st);
    case (op)
      2'h0: return ax < 1 || ax > 4 || axis_busy[ax-1];
      2'h1: return ax < 1 || ax > 6 || it < 1 || it > 3 || axis_busy[ax-1];
      default: return ax < 1 || ax > 4 || it < 1 || it > 17 || st > 400
        || (axis_busy[ax-1] && st == exec_step[ax-1] && held_m[ax-1]);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // One command through the software port, checked at the ports
  // ----------------------------------------------------------------
  task automatic do_cmd(input logic [1:0] op, input logic [2:0] ax, input logic [4:0] it,
    input logic [8:0] st, input logic nv, input logic [31:0] v);
    logic [31:0] stat;
    logic        bad;
    logic        held;
    int          nv0;
    int          wr0;
    nv0 = nv_seen;
    wr0 = wr_seen;
    sw_write(REG_VALUE, v);
    bad = exp_bad(op, ax, it, st);
    held = !bad && op == 2'h2 && axis_busy[ax-1] && st == exec_step[ax-1];
    sw_write(REG_SEL, {nv, 6'h00, st, 3'h0, it, 1'h0, ax, 2'h0, op});
    sw_write(REG_GO, 32'h0000_0000);
    stat = 32'h0000_0001;
    for (int i = 0; i < 8 && stat[ST_BUSY] !== 1'b0; i++)
      sw_read(REG_STATUS, stat);
    chk_bit(stat[ST_DONE], 1'b1);
    chk_bit(stat[ST_ERR], bad);
    if (!bad)
    begin
      if (op == 2'h0)
        pol_m[ax-1] = {8'h00, v[7:0]};
      if (op == 2'h1 && it == 5'h01)
        pulse_m = v[0];
      if (op == 2'h1 && it == 5'h02)
        ovr_m = v[0];
      if (op == 2'h1 && it == 5'h03 && v >= PERIOD_MIN && v <= PERIOD_MAX)
        per_m = v[3:0];
      if (op != 2'h1 && nv)
        nvcnt_m++;
      if (held)
        held_m[ax-1] = 1'b1;
    end
    chk_word(48'(nv_seen - nv0), 48'(!bad && nv));
    if (!bad && nv)
      chk_word(48'(nv_l), 48'({op, ax}));
    chk_word(48'(wr_seen - wr0), 48'(!bad && op == 2'h2 && !held));
    if (!bad && op == 2'h2 && !held)
      chk_word(wr_l, {2'(ax - 3'h1), it, st, v});
    for (int a = 0; a < NUM_AXES; a++)
      chk_word(48'(pol_word_r[a]), 48'(pol_m[a]));
    chk_word(48'({pulse_high_r, override_abs_r, ctrl_period_r}),
      48'({pulse_m, ovr_m, per_m}));
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    int          wr0;
    srst = 1'b1;
    sw_addr = 5'h00;
    sw_wdata = 32'h0000_0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    axis_busy = '0;
    exec_step = '1;
    step_done = '0;
    for (int a = 0; a < NUM_AXES; a++)
      pol_m[a] = POL_RESET;
    void'($urandom(80735));
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    do_cmd(2'h0, 3'h1, 5'h00, 9'h000, 1'b1, 32'hFFFF_FF43);
    do_cmd(2'h0, 3'h4, 5'h00, 9'h000, 1'b0, 32'h0000_00BC);
    do_cmd(2'h0, 3'h0, 5'h00, 9'h000, 1'b0, 32'h0000_0001);
    do_cmd(2'h1, 3'h6, 5'h01, 9'h000, 1'b1, 32'h0000_0001);
    do_cmd(2'h1, 3'h1, 5'h02, 9'h000, 1'b0, 32'h0000_0001);
    do_cmd(2'h1, 3'h1, 5'h03, 9'h000, 1'b0, 32'h0000_000A);
    do_cmd(2'h1, 3'h1, 5'h03, 9'h000, 1'b0, 32'h0000_000B);
    do_cmd(2'h1, 3'h1, 5'h03, 9'h000, 1'b0, 32'h0000_0000);
    do_cmd(2'h1, 3'h7, 5'h01, 9'h000, 1'b0, 32'h0000_0000);
    do_cmd(2'h1, 3'h1, 5'h04, 9'h000, 1'b0, 32'h0000_0000);
    do_cmd(2'h2, 3'h4, 5'h11, 9'h190, 1'b1, 32'h8000_0001);
    do_cmd(2'h2, 3'h1, 5'h12, 9'h000, 1'b0, 32'h0000_0001);
    do_cmd(2'h2, 3'h1, 5'h01, 9'h191, 1'b0, 32'h0000_0001);
    @(posedge clock);
    axis_busy <= 6'h12;
    do_cmd(2'h0, 3'h2, 5'h00, 9'h000, 1'b0, 32'h0000_00FF);
    do_cmd(2'h1, 3'h5, 5'h01, 9'h000, 1'b0, 32'h0000_0000);
    @(posedge clock);
    axis_busy <= 6'h01;
    exec_step[0] <= 9'h005;
    do_cmd(2'h2, 3'h1, 5'h04, 9'h005, 1'b0, 32'h0000_007D);
    do_cmd(2'h2, 3'h1, 5'h04, 9'h005, 1'b0, 32'h0000_0001);
    do_cmd(2'h2, 3'h1, 5'h04, 9'h006, 1'b1, 32'h0000_0009);
    wr0 = wr_seen;
    @(posedge clock);
    step_done <= 4'h1;
    @(posedge clock);
    step_done <= 4'h0;
    repeat (4) @(posedge clock);
    chk_word(48'(wr_seen - wr0), 48'h1);
    chk_word(wr_l, {2'h0, 5'h04, 9'h005, 32'h0000_007D});
    held_m = 4'h0;
    exec_step <= '1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clock);
      axis_busy <= 6'($urandom);
      do_cmd(2'($urandom_range(0, 2)), 3'($urandom), 5'($urandom_range(0, 18)),
        9'($urandom_range(0, 410)), 1'($urandom), $urandom);
    end
    sw_read(REG_NVCNT, d);
    chk_word(48'(d), 48'(nvcnt_m));
    sw_read(5'h14, d);
    chk_word(48'(d), 48'h0);
    print_verdict();
  end
endmodule // axis_param_teach_cmds_bench
`default_nettype wire
